// ===== rtl/mdcp_params.svh
// Constants for the dram channel pin link
`ifndef MDCP_PARAMS_SVH
`define MDCP_PARAMS_SVH
// Functional notes
// - Inputs captured on true clock rising edge
// - Each channel has own clock and pins
// - Clock enable low switches receivers, drivers off
// - Clock enable transitions enter and leave power-down
// - Chip select decoded as command code bit
// - Six-line command bus decoded per encoding
// - Termination from pin and mode bit
// - Sixteen-line data bus, direction by operation
// - Device drives strobe edge-aligned on reads
// - Controller strobe precedes write data
// - One strobe pair per byte lane
// - Mask-invert line high marks inverted byte
// - Inversion switchable off by mode bit
// - Mask-invert line carries write mask
// - Mode bit picks inversion or mask role
// - One mask-invert line per byte lane
// - Single active-low reset clears whole channel

// ----------------------------------------
// Widths
// ----------------------------------------
`define MDCP_DQ_W 16
`define MDCP_CA_W 6
`define MDCP_LANES 2
`define MDCP_BYTE_W 8
`define MDCP_AW 4
`define MDCP_MEM_DEPTH 16
`define MDCP_FIFO_DEPTH 16
`define MDCP_MR_W 3

// ----------------------------------------
// Command words, chip select in the top bit
// ----------------------------------------
`define MDCP_CMD_READ 7'h42
`define MDCP_CMD_WRITE 7'h44
`define MDCP_CMD_MRW 7'h46

// ----------------------------------------
// Timing and thresholds
// ----------------------------------------
`define MDCP_BURST 4
`define MDCP_DBI_LIMIT 4
`define MDCP_MR_RESET 3'h0

`endif

// ===== rtl/mdcp_pkg.sv
// Types for the dram channel pin link
`include "mdcp_params.svh"
package mdcp_pkg;

   typedef enum logic [1:0] {K_READ, K_WRITE, K_MRW} mdcp_kind_type;

   typedef struct packed {
      logic term_en;
      logic mask_mode;
      logic dbi_en;
   } mdcp_mode_type;

   typedef enum logic [2:0] {DEV_IDLE, DEV_ADDR, DEV_RD, DEV_REND, DEV_WR, DEV_PDOWN} mdcp_dev_st_type;

   typedef enum logic [2:0] {C_IDLE, C_ADDR, C_WPRE, C_WDATA, C_WEND, C_RWAIT, C_PDOWN} mdcp_ctl_st_type;

   typedef struct packed {
      mdcp_dev_st_type st;
      mdcp_kind_type kind;
      logic [`MDCP_AW-1:0] addr;
      logic [1:0] cnt;
      mdcp_mode_type mode;
      logic dqs_prev;
      logic [`MDCP_DQ_W-1:0] dq;
      logic [`MDCP_LANES-1:0] dqs_t;
      logic [`MDCP_LANES-1:0] dqs_c;
      logic [`MDCP_LANES-1:0] mi;
      logic oe;
      logic term_on;
      logic pdown;
      logic [`MDCP_MEM_DEPTH-1:0][`MDCP_DQ_W-1:0] mem;
   } mdcp_dev_state_type;

   typedef struct packed {
      mdcp_ctl_st_type st;
      logic ph;
      logic clk_p;
      logic clk_n;
      logic rst_out;
      logic cke;
      logic cs;
      logic [`MDCP_CA_W-1:0] ca;
      logic term;
      logic [`MDCP_DQ_W-1:0] dq;
      logic [`MDCP_LANES-1:0] dqs_t;
      logic [`MDCP_LANES-1:0] dqs_c;
      logic [`MDCP_LANES-1:0] mi;
      logic oe;
      mdcp_kind_type kind;
      logic [`MDCP_CA_W-1:0] addr;
      logic [1:0] cnt;
      mdcp_mode_type mode;
      logic dqs_prev;
      logic cmd_ready;
      logic rd_valid;
      logic [`MDCP_DQ_W-1:0] rd_data;
      logic pd_active;
   } mdcp_ctl_state_type;

endpackage : mdcp_pkg

// ===== rtl/mdcp_link_if.sv
// One channel of the dram pin link between controller and device
`timescale 1ns/1ps
`include "mdcp_params.svh"
interface mdcp_link_if;
   logic clk_pos_in;
   logic clk_neg_in;
   logic reset_n;
   logic cke;
   logic cs;
   logic cmd_term_ctrl;
   logic [`MDCP_CA_W-1:0] cmd_addr_bus;
   logic [`MDCP_DQ_W-1:0] ctl_dq;
   logic [`MDCP_DQ_W-1:0] dev_dq;
   logic [`MDCP_LANES-1:0] ctl_dqs_t;
   logic [`MDCP_LANES-1:0] ctl_dqs_c;
   logic [`MDCP_LANES-1:0] dev_dqs_t;
   logic [`MDCP_LANES-1:0] dev_dqs_c;
   logic [`MDCP_LANES-1:0] ctl_mi;
   logic [`MDCP_LANES-1:0] dev_mi;
   logic ctl_oe;
   logic dev_oe;
   logic [`MDCP_DQ_W-1:0] dq;
   logic [`MDCP_LANES-1:0] dqs_t;
   logic [`MDCP_LANES-1:0] dqs_c;
   logic [`MDCP_LANES-1:0] mask_invert_line;

   // ----------------------------------------
   // Wire resolution, undriven reads as zero
   // ----------------------------------------
   assign dq = dev_oe ? dev_dq : (ctl_oe ? ctl_dq : '0);
   assign dqs_t = dev_oe ? dev_dqs_t : (ctl_oe ? ctl_dqs_t : '0);
   assign dqs_c = dev_oe ? dev_dqs_c : (ctl_oe ? ctl_dqs_c : '0);
   assign mask_invert_line = dev_oe ? dev_mi : (ctl_oe ? ctl_mi : '0);

   modport ctrl (
      output clk_pos_in, clk_neg_in, reset_n, cke, cs, cmd_term_ctrl, cmd_addr_bus,
      output ctl_dq, ctl_dqs_t, ctl_dqs_c, ctl_mi, ctl_oe,
      input dq, dqs_t, mask_invert_line
   );

   modport dev (
      input clk_pos_in, reset_n, cke, cs, cmd_term_ctrl, cmd_addr_bus,
      input dq, dqs_t, mask_invert_line,
      output dev_dq, dev_dqs_t, dev_dqs_c, dev_mi, dev_oe
   );
endinterface : mdcp_link_if

// ===== rtl/mdcp_device.sv
// Device end of one dram channel
`timescale 1ns/1ps
`include "mdcp_params.svh"
module mdcp_device (
   mdcp_link_if.dev lk,
   output logic power_down,
   output logic term_on,
   output logic dbi_on,
   output logic mask_on
);
   mdcp_pkg::mdcp_dev_state_type st_reg;
   mdcp_pkg::mdcp_dev_state_type st_next;
   logic [`MDCP_DQ_W-1:0] rd_word;
   logic [`MDCP_DQ_W-1:0] rd_lane;
   logic [`MDCP_DQ_W-1:0] wr_merge;
   logic [`MDCP_LANES-1:0] rd_inv;
   logic [`MDCP_CA_W:0] cmd_word;
   logic last;

   assign rd_word = st_reg.mem[st_reg.addr];
   assign cmd_word = {lk.cs, lk.cmd_addr_bus};
   assign last = st_reg.cnt == 2'(`MDCP_BURST - 1);

   // ----------------------------------------
   // Per byte lane inversion and mask
   // ----------------------------------------
   genvar gl;
   generate
      for (gl = 0; gl < `MDCP_LANES; gl++) begin : g_lane
         logic flip;
         logic keep;
         logic [`MDCP_BYTE_W-1:0] old_b;
         logic [`MDCP_BYTE_W-1:0] in_b;
         assign old_b = rd_word[gl*`MDCP_BYTE_W +: `MDCP_BYTE_W];
         assign in_b = lk.dq[gl*`MDCP_BYTE_W +: `MDCP_BYTE_W];
         assign rd_inv[gl] = st_reg.mode.dbi_en && !st_reg.mode.mask_mode
            && ($countones(old_b) > `MDCP_DBI_LIMIT);
         assign rd_lane[gl*`MDCP_BYTE_W +: `MDCP_BYTE_W] = rd_inv[gl] ? ~old_b : old_b;
         assign flip = !st_reg.mode.mask_mode && st_reg.mode.dbi_en
            && lk.mask_invert_line[gl];
         assign keep = !(st_reg.mode.mask_mode && lk.mask_invert_line[gl]);
         assign wr_merge[gl*`MDCP_BYTE_W +: `MDCP_BYTE_W] = !keep ? old_b : (flip ? ~in_b : in_b);
      end
   endgenerate

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.term_on = lk.cmd_term_ctrl && st_reg.mode.term_en;
      st_next.dqs_prev = lk.dqs_t[0];
      case (st_reg.st)
         mdcp_pkg::DEV_IDLE: begin
            if (cmd_word == `MDCP_CMD_READ) begin
               st_next.kind = mdcp_pkg::K_READ;
               st_next.st = mdcp_pkg::DEV_ADDR;
            end else if (cmd_word == `MDCP_CMD_WRITE) begin
               st_next.kind = mdcp_pkg::K_WRITE;
               st_next.st = mdcp_pkg::DEV_ADDR;
            end else if (cmd_word == `MDCP_CMD_MRW) begin
               st_next.kind = mdcp_pkg::K_MRW;
               st_next.st = mdcp_pkg::DEV_ADDR;
            end
         end
         mdcp_pkg::DEV_ADDR: begin
            st_next.addr = lk.cmd_addr_bus[`MDCP_AW-1:0];
            st_next.cnt = '0;
            st_next.st = mdcp_pkg::DEV_IDLE;
            if (st_reg.kind == mdcp_pkg::K_MRW) begin
               st_next.mode = mdcp_pkg::mdcp_mode_type'(lk.cmd_addr_bus[`MDCP_MR_W-1:0]);
            end else if (st_reg.kind == mdcp_pkg::K_WRITE) begin
               st_next.st = mdcp_pkg::DEV_WR;
            end else begin
               st_next.st = mdcp_pkg::DEV_RD;
               st_next.oe = 1'b1;
               st_next.dqs_t = '0;
               st_next.dqs_c = '1;
            end
         end
         mdcp_pkg::DEV_RD: begin
            st_next.dq = rd_lane;
            st_next.mi = rd_inv;
            st_next.dqs_t = ~st_reg.dqs_t;
            st_next.dqs_c = ~st_reg.dqs_c;
            st_next.addr = st_reg.addr + 1'b1;
            st_next.cnt = st_reg.cnt + 1'b1;
            if (last) begin
               st_next.st = mdcp_pkg::DEV_REND;
            end
         end
         mdcp_pkg::DEV_REND: begin
            st_next.oe = 1'b0;
            st_next.dqs_t = '0;
            st_next.dqs_c = '0;
            st_next.mi = '0;
            st_next.st = mdcp_pkg::DEV_IDLE;
         end
         mdcp_pkg::DEV_WR: begin
            if (lk.dqs_t[0] != st_reg.dqs_prev) begin
               st_next.mem[st_reg.addr] = wr_merge;
               st_next.addr = st_reg.addr + 1'b1;
               st_next.cnt = st_reg.cnt + 1'b1;
               if (last) begin
                  st_next.st = mdcp_pkg::DEV_IDLE;
               end
            end
         end
         mdcp_pkg::DEV_PDOWN: begin
            if (lk.cke) begin
               st_next.pdown = 1'b0;
               st_next.st = mdcp_pkg::DEV_IDLE;
            end
         end
         default: begin
            st_next.st = mdcp_pkg::DEV_IDLE;
         end
      endcase
      if (!lk.cke) begin
         st_next.st = mdcp_pkg::DEV_PDOWN;
         st_next.pdown = 1'b1;
         st_next.oe = 1'b0;
         st_next.dqs_t = '0;
         st_next.dqs_c = '0;
         st_next.mi = '0;
      end
   end

   always_ff @(posedge lk.clk_pos_in or negedge lk.reset_n) begin
      if (!lk.reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign lk.dev_dq = st_reg.dq;
   assign lk.dev_dqs_t = st_reg.dqs_t;
   assign lk.dev_dqs_c = st_reg.dqs_c;
   assign lk.dev_mi = st_reg.mi;
   assign lk.dev_oe = st_reg.oe;
   assign power_down = st_reg.pdown;
   assign term_on = st_reg.term_on;
   assign dbi_on = st_reg.mode.dbi_en;
   assign mask_on = st_reg.mode.mask_mode;
endmodule : mdcp_device

// ===== rtl/mdcp_ctrl.sv
// Controller end of one dram channel with its write data fifo
`timescale 1ns/1ps
`include "mdcp_params.svh"

// ----------------------------------------
// Write data fifo
// ----------------------------------------
module mdcp_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } mdcp_fifo_state_type;

   mdcp_fifo_state_type st_reg;
   mdcp_fifo_state_type st_next;
   logic push;
   logic pop;

   assign in_ready = st_reg.cnt != FULL;
   assign out_valid = st_reg.cnt != '0;
   assign out_data = st_reg.mem[st_reg.rp];
   assign level = st_reg.cnt;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wp] = in_data;
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (pop) begin
         st_next.rp = st_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : mdcp_fifo

// ----------------------------------------
// Channel controller
// ----------------------------------------
module mdcp_ctrl (
   mdcp_link_if.ctrl lk,
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic cmd_valid,
   input wire mdcp_pkg::mdcp_kind_type cmd_kind,
   input wire logic [`MDCP_CA_W-1:0] cmd_addr,
   output logic cmd_ready,
   input wire logic wr_valid,
   input wire logic [`MDCP_DQ_W-1:0] wr_data,
   input wire logic [`MDCP_LANES-1:0] wr_mask,
   output logic wr_ready,
   output logic rd_valid,
   output logic [`MDCP_DQ_W-1:0] rd_data,
   input wire logic pd_req,
   input wire logic term_req,
   output logic pd_active
);
   localparam int FW = `MDCP_DQ_W + `MDCP_LANES;

   mdcp_pkg::mdcp_ctl_state_type st_reg;
   mdcp_pkg::mdcp_ctl_state_type st_next;
   logic pop;
   logic f_valid;
   logic [FW-1:0] f_data;
   logic [$clog2(`MDCP_FIFO_DEPTH):0] f_level;
   logic [`MDCP_DQ_W-1:0] wr_lane;
   logic [`MDCP_LANES-1:0] wr_mi;
   logic [`MDCP_DQ_W-1:0] rd_lane;
   logic last;

   mdcp_fifo #(
      .WIDTH(FW),
      .DEPTH(`MDCP_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data({wr_mask, wr_data}),
      .out_valid(f_valid),
      .out_ready(pop),
      .out_data(f_data),
      .level(f_level)
   );

   assign last = st_reg.cnt == 2'(`MDCP_BURST - 1);

   // ----------------------------------------
   // Per byte lane inversion and mask
   // ----------------------------------------
   genvar gl;
   generate
      for (gl = 0; gl < `MDCP_LANES; gl++) begin : g_lane
         logic inv;
         logic [`MDCP_BYTE_W-1:0] wb;
         logic [`MDCP_BYTE_W-1:0] rb;
         assign wb = f_data[gl*`MDCP_BYTE_W +: `MDCP_BYTE_W];
         assign rb = lk.dq[gl*`MDCP_BYTE_W +: `MDCP_BYTE_W];
         assign inv = st_reg.mode.dbi_en && !st_reg.mode.mask_mode
            && ($countones(wb) > `MDCP_DBI_LIMIT);
         assign wr_lane[gl*`MDCP_BYTE_W +: `MDCP_BYTE_W] = inv ? ~wb : wb;
         assign wr_mi[gl] = st_reg.mode.mask_mode ? f_data[`MDCP_DQ_W + gl] : inv;
         assign rd_lane[gl*`MDCP_BYTE_W +: `MDCP_BYTE_W] = (st_reg.mode.dbi_en
            && !st_reg.mode.mask_mode && lk.mask_invert_line[gl]) ? ~rb : rb;
      end
   endgenerate

   // ----------------------------------------
   // Next state, link moves on falling edges
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      pop = 1'b0;
      st_next.ph = !st_reg.ph;
      st_next.clk_p = !st_reg.ph;
      st_next.clk_n = st_reg.ph;
      st_next.rst_out = 1'b1;
      st_next.term = term_req;
      st_next.cmd_ready = 1'b0;
      st_next.rd_valid = 1'b0;
      if (st_reg.ph) begin
         case (st_reg.st)
            mdcp_pkg::C_IDLE: begin
               st_next.cs = 1'b0;
               st_next.cke = 1'b1;
               if (pd_req) begin
                  st_next.cke = 1'b0;
                  st_next.pd_active = 1'b1;
                  st_next.st = mdcp_pkg::C_PDOWN;
               end else if (cmd_valid && (cmd_kind != mdcp_pkg::K_WRITE
                  || f_level >= `MDCP_BURST)) begin
                  if (cmd_kind == mdcp_pkg::K_READ) begin
                     {st_next.cs, st_next.ca} = `MDCP_CMD_READ;
                  end else if (cmd_kind == mdcp_pkg::K_WRITE) begin
                     {st_next.cs, st_next.ca} = `MDCP_CMD_WRITE;
                  end else begin
                     {st_next.cs, st_next.ca} = `MDCP_CMD_MRW;
                  end
                  st_next.kind = cmd_kind;
                  st_next.addr = cmd_addr;
                  st_next.cmd_ready = 1'b1;
                  st_next.st = mdcp_pkg::C_ADDR;
               end
            end
            mdcp_pkg::C_ADDR: begin
               st_next.cs = 1'b0;
               st_next.ca = st_reg.addr;
               st_next.cnt = '0;
               st_next.dqs_prev = 1'b0;
               if (st_reg.kind == mdcp_pkg::K_MRW) begin
                  st_next.mode = mdcp_pkg::mdcp_mode_type'(st_reg.addr[`MDCP_MR_W-1:0]);
                  st_next.st = mdcp_pkg::C_IDLE;
               end else if (st_reg.kind == mdcp_pkg::K_WRITE) begin
                  st_next.st = mdcp_pkg::C_WPRE;
               end else begin
                  st_next.st = mdcp_pkg::C_RWAIT;
               end
            end
            mdcp_pkg::C_WPRE: begin
               st_next.oe = 1'b1;
               st_next.dqs_t = '0;
               st_next.dqs_c = '1;
               st_next.mi = '0;
               st_next.st = mdcp_pkg::C_WDATA;
            end
            mdcp_pkg::C_WDATA: begin
               pop = f_valid;
               st_next.dq = wr_lane;
               st_next.mi = wr_mi;
               st_next.dqs_t = ~st_reg.dqs_t;
               st_next.dqs_c = ~st_reg.dqs_c;
               st_next.cnt = st_reg.cnt + 1'b1;
               if (last) begin
                  st_next.st = mdcp_pkg::C_WEND;
               end
            end
            mdcp_pkg::C_WEND: begin
               st_next.oe = 1'b0;
               st_next.dqs_t = '0;
               st_next.dqs_c = '0;
               st_next.mi = '0;
               st_next.st = mdcp_pkg::C_IDLE;
            end
            mdcp_pkg::C_RWAIT: begin
               if (lk.dqs_t[0] != st_reg.dqs_prev) begin
                  st_next.dqs_prev = lk.dqs_t[0];
                  st_next.rd_valid = 1'b1;
                  st_next.rd_data = rd_lane;
                  st_next.cnt = st_reg.cnt + 1'b1;
                  if (last) begin
                     st_next.st = mdcp_pkg::C_IDLE;
                  end
               end
            end
            mdcp_pkg::C_PDOWN: begin
               if (!pd_req) begin
                  st_next.cke = 1'b1;
                  st_next.pd_active = 1'b0;
                  st_next.st = mdcp_pkg::C_IDLE;
               end
            end
            default: begin
               st_next.st = mdcp_pkg::C_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Pin and user outputs
   // ----------------------------------------
   assign lk.clk_pos_in = st_reg.clk_p;
   assign lk.clk_neg_in = st_reg.clk_n;
   assign lk.reset_n = st_reg.rst_out;
   assign lk.cke = st_reg.cke;
   assign lk.cs = st_reg.cs;
   assign lk.cmd_addr_bus = st_reg.ca;
   assign lk.cmd_term_ctrl = st_reg.term;
   assign lk.ctl_dq = st_reg.dq;
   assign lk.ctl_dqs_t = st_reg.dqs_t;
   assign lk.ctl_dqs_c = st_reg.dqs_c;
   assign lk.ctl_mi = st_reg.mi;
   assign lk.ctl_oe = st_reg.oe;
   assign cmd_ready = st_reg.cmd_ready;
   assign rd_valid = st_reg.rd_valid;
   assign rd_data = st_reg.rd_data;
   assign pd_active = st_reg.pd_active;
endmodule : mdcp_ctrl

// ===== tb/mdcp_link_assertions.sv
// Wire checks on one dram channel link
`timescale 1ns/1ps
module mdcp_link_checker (
   input wire logic clk_pos_in,
   input wire logic reset_n,
   input wire logic cke,
   input wire logic cs,
   input wire logic [5:0] cmd_addr_bus,
   input wire logic [1:0] dqs_t,
   input wire logic [1:0] dqs_c,
   input wire logic ctl_oe,
   input wire logic dev_oe
);
   // ----------------------------------------
   // Link clock domain checks
   // ----------------------------------------
   default clocking cb @(posedge clk_pos_in); endclocking
   default disable iff (!reset_n);

   a_read_drive_window: assert property (cke && cs && cmd_addr_bus == 6'h02 |=>
      !dev_oe ##1 dev_oe [*5] ##1 !dev_oe) else $error("read drive window wrong");
   a_read_preamble: assert property ($rose(dev_oe) |-> dqs_t == 2'h0)
      else $error("read preamble wrong");
   a_read_strobe_edge: assert property (dev_oe && $past(dev_oe) |-> dqs_t != $past(dqs_t)
      && dqs_c == ~dqs_t && dqs_t[0] == dqs_t[1]) else $error("read strobe not toggling");
   a_pdown_release: assert property (!cke |=> !dev_oe)
      else $error("device drives in power down");
   a_no_contention: assert property (!(dev_oe && ctl_oe))
      else $error("both ends drive data");
   a_write_drive_window: assert property (cke && cs && cmd_addr_bus == 6'h04 |=>
      !ctl_oe ##1 ctl_oe [*5] ##1 !ctl_oe) else $error("write drive window wrong");
   a_write_strobe_first: assert property ($rose(ctl_oe) |-> dqs_t == 2'h0 ##1
      dqs_t == 2'h3 ##1 dqs_t == 2'h0 ##1 dqs_t == 2'h3 ##1 dqs_t == 2'h0)
      else $error("write strobe order wrong");
   a_cmd_awake: assert property (cs |-> cke)
      else $error("command while clock enable low");

   c_read: cover property (cke && cs && cmd_addr_bus == 6'h02);
   c_write: cover property ($rose(ctl_oe));
   c_pdown: cover property ($fell(cke));
endmodule : mdcp_link_checker

// ===== tb/test_mobile_dram_channel_pins.sv
// Self-checking bench for one dram channel, controller against device
`timescale 1ns/1ps
module test_mobile_dram_channel_pins;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic cmd_valid = 1'b0;
   mdcp_pkg::mdcp_kind_type cmd_kind = mdcp_pkg::K_READ;
   logic [5:0] cmd_addr = 6'h00;
   logic wr_valid = 1'b0;
   logic [15:0] wr_data = 16'h0000;
   logic [1:0] wr_mask = 2'h0;
   logic pd_req = 1'b0;
   logic term_req = 1'b0;
   logic cmd_ready, wr_ready, rd_valid, pd_active, power_down, term_on, dbi_on, mask_on;
   logic [15:0] rd_data;
   logic [15:0] mem [16];
   logic [7:0] wb;
   logic mask_q = 1'b0;
   int n_errors = 0;
   int num_checks = 0;

   mdcp_link_if mdcp_link_if_inst ();
   mdcp_ctrl mdcp_ctrl_inst (.lk(mdcp_link_if_inst), .clk_sys(clk_sys), .arst_n(arst_n),
      .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
      .wr_valid(wr_valid), .wr_data(wr_data), .wr_mask(wr_mask), .wr_ready(wr_ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .pd_req(pd_req), .term_req(term_req),
      .pd_active(pd_active));
   mdcp_device mdcp_device_inst (.lk(mdcp_link_if_inst), .power_down(power_down),
      .term_on(term_on), .dbi_on(dbi_on), .mask_on(mask_on));
   mdcp_link_checker mdcp_link_checker_inst (.clk_pos_in(mdcp_link_if_inst.clk_pos_in),
      .reset_n(mdcp_link_if_inst.reset_n), .cke(mdcp_link_if_inst.cke),
      .cs(mdcp_link_if_inst.cs), .cmd_addr_bus(mdcp_link_if_inst.cmd_addr_bus),
      .dqs_t(mdcp_link_if_inst.dqs_t), .dqs_c(mdcp_link_if_inst.dqs_c),
      .ctl_oe(mdcp_link_if_inst.ctl_oe), .dev_oe(mdcp_link_if_inst.dev_oe));

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic bail(input string what);
      n_errors++;
      $display("mismatch %s expected handshake seen timeout", what);
      wrap_up();
   endtask : bail

   task automatic issue(input mdcp_pkg::mdcp_kind_type k, input logic [5:0] a);
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_addr = a;
      for (int i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
      if (cmd_ready !== 1'b1) bail("cmd_ready");
      cmd_valid = 1'b0;
   endtask : issue

   task automatic push(input logic [15:0] d, input logic [1:0] m);
      @(negedge clk_sys);
      wr_valid = 1'b1;
      wr_data = d;
      wr_mask = m;
      for (int i = 0; i < 100 && wr_ready !== 1'b1; i++) @(negedge clk_sys);
      if (wr_ready !== 1'b1) bail("wr_ready");
      @(negedge clk_sys);
      wr_valid = 1'b0;
   endtask : push

   task automatic load(input logic [3:0] a, input logic [15:0] d, input logic [1:0] m);
      logic [15:0] dd;
      for (int k = 0; k < 4; k++) begin
         dd = d + 16'(k);
         push(dd, m);
         if (!mask_q || !m[0]) mem[4'(a + k)][7:0] = dd[7:0];
         if (!mask_q || !m[1]) mem[4'(a + k)][15:8] = dd[15:8];
      end
   endtask : load

   task automatic rd(input logic [3:0] a);
      int n;
      issue(mdcp_pkg::K_READ, {2'h0, a});
      n = 0;
      for (int i = 0; i < 100 && n < 4; i++) begin
         @(negedge clk_sys);
         if (rd_valid === 1'b1) begin
            chk("rd_data", mem[4'(a + n)], rd_data);
            n++;
         end
      end
      if (n != 4) bail("rd_valid");
   endtask : rd

   task automatic mode(input logic [2:0] v);
      issue(mdcp_pkg::K_MRW, {3'h0, v});
      mask_q = v[1];
      for (int i = 0; i < 50 && {mask_on, dbi_on} !== v[1:0]; i++) @(negedge clk_sys);
      if ({mask_on, dbi_on} !== v[1:0]) bail("mode");
      chk("mode", 16'(v[1:0]), 16'({mask_on, dbi_on}));
   endtask : mode

   always @(posedge mdcp_link_if_inst.clk_pos_in) begin
      if (mdcp_link_if_inst.dev_oe && mdcp_link_if_inst.dqs_t[0] && dbi_on && !mask_on) begin
         for (int b = 0; b < 2; b++) begin
            wb = mdcp_link_if_inst.mask_invert_line[b] ? ~mdcp_link_if_inst.dq[8*b +: 8]
               : mdcp_link_if_inst.dq[8*b +: 8];
            chk("dbi_flag", 16'($countones(wb) > 4), 16'(mdcp_link_if_inst.mask_invert_line[b]));
         end
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
      repeat (3) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (8) @(negedge clk_sys);
      chk("pd_active", 16'h0000, 16'(pd_active));
      repeat (2) begin
         @(negedge clk_sys);
         chk("clk_neg_in", 16'(!mdcp_link_if_inst.clk_pos_in),
            16'(mdcp_link_if_inst.clk_neg_in));
      end
      rd(4'h0);
      for (int i = 0; i < 4; i++) load(4'(14 + 4 * i), 16'ha000 + 16'(i * 4096), 2'h3);
      chk("wr_ready", 16'h0000, 16'(wr_ready));
      for (int i = 0; i < 4; i++) issue(mdcp_pkg::K_WRITE, 6'(4'(14 + 4 * i)));
      rd(4'he);
      rd(4'h6);
      mode(3'h1);
      load(4'h8, 16'hf0ff, 2'h0);
      issue(mdcp_pkg::K_WRITE, 6'h08);
      rd(4'h8);
      mode(3'h2);
      load(4'h8, 16'h1234, 2'h1);
      issue(mdcp_pkg::K_WRITE, 6'h08);
      rd(4'h8);
      term_req = 1'b1;
      repeat (8) @(negedge clk_sys);
      chk("term_on", 16'h0000, 16'(term_on));
      mode(3'h4);
      repeat (8) @(negedge clk_sys);
      chk("term_on", 16'h0001, 16'(term_on));
      term_req = 1'b0;
      repeat (8) @(negedge clk_sys);
      chk("term_on", 16'h0000, 16'(term_on));
      pd_req = 1'b1;
      for (int i = 0; i < 50 && pd_active !== 1'b1; i++) @(negedge clk_sys);
      if (pd_active !== 1'b1) bail("pd_active");
      repeat (8) @(negedge clk_sys);
      chk("power_down", 16'h0001, 16'(power_down));
      pd_req = 1'b0;
      for (int i = 0; i < 50 && pd_active !== 1'b0; i++) @(negedge clk_sys);
      if (pd_active !== 1'b0) bail("pd_active");
      repeat (8) @(negedge clk_sys);
      chk("power_down", 16'h0000, 16'(power_down));
      rd(4'h8);
      arst_n = 1'b0;
      repeat (3) @(negedge clk_sys);
      arst_n = 1'b1;
      for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
      mask_q = 1'b0;
      repeat (8) @(negedge clk_sys);
      chk("mode", 16'h0000, 16'({term_on, mask_on, dbi_on}));
      rd(4'h8);
      wrap_up();
   end
endmodule : test_mobile_dram_channel_pins
